/* File: hdl/wdlvr_pkg.sv */
// What this block does
// R1: Watchdog overflow while enabled requests a device reset.
// R2: Guard key 10101b disables the watchdog; no overflow resets.
// R3: Guard key 01010b enables the watchdog and lets it count.
// R4: Any other guard key resets the device two to three slow ticks later.
// R5: Guard key powers up holding the enable code.
// R6: Overflow in normal running gives a full reset and sets the timeout flag.
// R7: Overflow in sleep or idle sets timeout flag, clears only PC and stack pointer.
// R8: Counter cleared by any reset, overflow, clear instruction, power-down instruction or disabling.
// R9: Timeout spans 2^8 up to 2^18 slow tick periods.
// R10: Power-on reset forces the program counter to zero.
// R11: Power-on reset presets all port data and control registers to ones.
// R12: Qualified undervoltage resets the device and sets the undervoltage flag.
// R13: Undervoltage shorter than the minimum duration is ignored.
// R14: Threshold select accepts only 55h, 33h, 99h and aah.
// R15: Illegal threshold select resets two to three slow ticks later, sets fault flag.
// R16: After an illegal threshold reset the select returns to its power-on value.
// R17: After an undervoltage reset the threshold select keeps its contents.
// R18: Threshold select powers up holding 55h.
// R19: Undervoltage reset is disabled during sleep or idle.
// R20: Period select codes 0..7 give 2^8,10,12,14,15,16,17,18 ticks.
// R21: Key fault flag set by a key-fault reset, cleared only by software.
// R22: Watchdog counter advances on the slow oscillator tick.
// R23: Undervoltage and threshold fault flags stay set until software clears them.
// R24: Key faults, undervoltage and overflow outside sleep merge into one registered full reset request, each with its own flag.
// R25: Counter restarts from zero after every clear and stays zero while disabled.
package wdlvr_pkg;
    // Register offsets
    localparam logic [3:0] ADDR_WDT_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_RST_CTRL   = 4'h1;
    localparam logic [3:0] ADDR_LV_SELECT  = 4'h2;
    localparam logic [3:0] ADDR_STATUS     = 4'h3;

    // Guard key and period select fields of the watchdog control register
    localparam int         KEY_LSB         = 3;
    localparam logic [4:0] KEY_DISABLE     = 5'h15;
    localparam logic [4:0] KEY_ENABLE      = 5'h0a;
    localparam logic [7:0] WDT_CTRL_POR    = 8'h53;

    // Threshold select legal codes
    localparam logic [7:0] LV_CODE_A       = 8'h55;
    localparam logic [7:0] LV_CODE_B       = 8'h33;
    localparam logic [7:0] LV_CODE_C       = 8'h99;
    localparam logic [7:0] LV_CODE_D       = 8'haa;
    localparam logic [7:0] LV_SELECT_POR   = 8'h55;

    // Reset flag bit positions in the reset control register
    localparam int         BIT_WKEY_FAULT  = 0;
    localparam int         BIT_LKEY_FAULT  = 1;
    localparam int         BIT_UV_FLAG     = 2;

    // Status register bit positions
    localparam int         BIT_TIMEOUT     = 0;
    localparam int         BIT_WDT_RUN     = 1;
    localparam int         BIT_RST_BUSY    = 2;

    // Timing
    localparam int         CLK_NS          = 20;
    localparam int         UV_MIN_NS       = 1000;
    localparam int         UV_MIN_CYCLES   = (UV_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] KEY_DELAY_TICKS = 2'h3;
    localparam logic [2:0] RESET_HOLD      = 3'h4;
    localparam int         CNT_W           = 18;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_FULL = 3'b010,
        ST_WAKE = 3'b100
    } wdlvr_state_t;
endpackage : wdlvr_pkg

/* File: hdl/wdlvr_top.sv */
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module wdlvr_top (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // Register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output var  logic [7:0] rdata_o,
    // Processor events
    input  wire logic       watchdog_clear_instr_i,
    input  wire logic       halt_i,
    input  wire logic       sleep_i,
    // Asynchronous pins
    input  wire logic       slow_osc_i,
    input  wire logic       undervolt_i,
    // Reset outputs
    output var  logic       full_reset_o,
    output var  logic       pc_sp_clear_o,
    output var  logic       port_preset_o
);
    // Slow oscillator and undervoltage synchronisers
    logic                 osc_s1, osc_s2, osc_s3, osc_lvl, tick;
    logic                 uv_s1, uv_s2, uv_s3, uv_lvl;
    logic                 next_osc_lvl, next_tick, next_uv_lvl;

    always_comb begin
        next_osc_lvl = (osc_s2 == osc_s3) ? osc_s3 : osc_lvl;
        next_tick    = next_osc_lvl & ~osc_lvl;                        // [R22]
        next_uv_lvl  = (uv_s2 == uv_s3) ? uv_s3 : uv_lvl;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            osc_s1  <= 1'b0;
            osc_s2  <= 1'b0;
            osc_s3  <= 1'b0;
            osc_lvl <= 1'b0;
            tick    <= 1'b0;
            uv_s1   <= 1'b0;
            uv_s2   <= 1'b0;
            uv_s3   <= 1'b0;
            uv_lvl  <= 1'b0;
        end else begin
            osc_s1  <= slow_osc_i;
            osc_s2  <= osc_s1;
            osc_s3  <= osc_s2;
            osc_lvl <= next_osc_lvl;
            tick    <= next_tick;
            uv_s1   <= undervolt_i;
            uv_s2   <= uv_s1;
            uv_s3   <= uv_s2;
            uv_lvl  <= next_uv_lvl;
        end
    end

    // Control state
    wdlvr_pkg::wdlvr_state_t state, next_state;
    logic [7:0]           wdt_ctrl, next_wdt_ctrl;
    logic [7:0]           lv_sel, next_lv_sel;
    logic [wdlvr_pkg::CNT_W-1:0] cnt, next_cnt;
    logic [1:0]           wkey_ticks, next_wkey_ticks;
    logic [1:0]           lkey_ticks, next_lkey_ticks;
    logic [6:0]           uv_cnt, next_uv_cnt;
    logic [2:0]           hold, next_hold;
    logic                 timeout_flag, next_timeout_flag;
    logic                 wdt_key_fault_flag, next_wdt_key_fault_flag;
    logic                 threshold_key_fault_flag, next_threshold_key_fault_flag;
    logic                 undervolt_reset_flag, next_undervolt_reset_flag;
    logic                 next_full, next_pc_sp, next_port;
    logic [7:0]           next_rdata;

    // Decoded conditions
    logic [4:0]           wdt_guard_key;
    logic [2:0]           wdt_period_sel;
    logic                 wdt_on, key_bad, lv_bad, overflow;
    logic                 wkey_fire, lkey_fire, uv_fire, wr_rst_ctrl;
    logic [wdlvr_pkg::CNT_W-1:0] limit;

    always_comb begin
        wdt_guard_key  = wdt_ctrl[7:wdlvr_pkg::KEY_LSB];
        wdt_period_sel = wdt_ctrl[2:0];
        wdt_on  = (wdt_guard_key == wdlvr_pkg::KEY_ENABLE);                 // [R2] [R3]
        key_bad = (wdt_guard_key != wdlvr_pkg::KEY_ENABLE)
                  && (wdt_guard_key != wdlvr_pkg::KEY_DISABLE);            // [R4]
        lv_bad  = (lv_sel != wdlvr_pkg::LV_CODE_A) && (lv_sel != wdlvr_pkg::LV_CODE_B)
                  && (lv_sel != wdlvr_pkg::LV_CODE_C)
                  && (lv_sel != wdlvr_pkg::LV_CODE_D);                      // [R14]
        unique case (wdt_period_sel)                                        // [R9] [R20]
            3'h0:    limit = 18'h000ff;
            3'h1:    limit = 18'h003ff;
            3'h2:    limit = 18'h00fff;
            3'h3:    limit = 18'h03fff;
            3'h4:    limit = 18'h07fff;
            3'h5:    limit = 18'h0ffff;
            3'h6:    limit = 18'h1ffff;
            3'h7:    limit = 18'h3ffff;
        endcase
        overflow    = wdt_on && tick && (cnt == limit) && (state == wdlvr_pkg::ST_RUN); // [R1]
        // A fault whose third tick lands while busy fires on a later tick, never lost
        wkey_fire   = key_bad && tick && (wkey_ticks >= wdlvr_pkg::KEY_DELAY_TICKS - 2'h1);
        lkey_fire   = lv_bad && tick && (lkey_ticks >= wdlvr_pkg::KEY_DELAY_TICKS - 2'h1);
        uv_fire     = !sleep_i
                      && (uv_cnt == 7'(wdlvr_pkg::UV_MIN_CYCLES - 1)) && uv_lvl; // [R13] [R19]
        wr_rst_ctrl = wr_i && (addr_i == wdlvr_pkg::ADDR_RST_CTRL);
    end

    // Next-state computation
    always_comb begin
        next_state      = state;
        next_hold       = hold;
        next_wdt_ctrl   = wdt_ctrl;
        next_lv_sel     = lv_sel;
        next_cnt        = cnt;
        next_wkey_ticks = wkey_ticks;
        next_lkey_ticks = lkey_ticks;
        next_uv_cnt     = uv_cnt;
        next_full       = 1'b0;
        next_pc_sp      = 1'b0;
        next_port       = 1'b0;
        next_timeout_flag = timeout_flag;

        // Software writes to control registers
        if (wr_i && addr_i == wdlvr_pkg::ADDR_WDT_CTRL) begin
            next_wdt_ctrl = wdata_i;
        end
        if (wr_i && addr_i == wdlvr_pkg::ADDR_LV_SELECT) begin
            next_lv_sel = wdata_i;
        end

        // Watchdog counter on the slow tick
        if (!wdt_on || watchdog_clear_instr_i || halt_i) begin
            next_cnt = '0;                                                  // [R8] [R25]
        end else if (tick) begin
            next_cnt = (cnt == limit) ? '0 : cnt + 1'b1;                    // [R22]
        end
        if (halt_i) begin
            next_timeout_flag = 1'b0;
        end

        // Key fault delay, counted in slow ticks so it tracks the oscillator
        if (!key_bad) begin
            next_wkey_ticks = 2'h0;
        end else if (tick && wkey_ticks != wdlvr_pkg::KEY_DELAY_TICKS) begin
            next_wkey_ticks = wkey_ticks + 2'h1;                            // [R4]
        end
        if (!lv_bad) begin
            next_lkey_ticks = 2'h0;
        end else if (tick && lkey_ticks != wdlvr_pkg::KEY_DELAY_TICKS) begin
            next_lkey_ticks = lkey_ticks + 2'h1;                            // [R15]
        end

        // Undervoltage qualification; glitches restart the count
        if (!uv_lvl || sleep_i) begin
            next_uv_cnt = 7'h00;                                            // [R13] [R19]
        end else if (uv_cnt != 7'(wdlvr_pkg::UV_MIN_CYCLES - 1)) begin
            next_uv_cnt = uv_cnt + 7'h01;
        end

        unique case (state)
            wdlvr_pkg::ST_RUN: begin
                if (wkey_fire || lkey_fire || uv_fire
                    || (overflow && !sleep_i)) begin                        // [R24]
                    next_state      = wdlvr_pkg::ST_FULL;
                    next_hold       = wdlvr_pkg::RESET_HOLD - 3'h1;
                    next_full       = 1'b1;                                 // [R1] [R6] [R12]
                    next_pc_sp      = 1'b1;                                 // [R10]
                    next_port       = 1'b1;                                 // [R11]
                    next_wdt_ctrl   = wdlvr_pkg::WDT_CTRL_POR;
                    next_cnt        = '0;                                   // [R8]
                    next_wkey_ticks = 2'h0;
                    next_lkey_ticks = 2'h0;
                    next_uv_cnt     = 7'h00;
                    // An undervoltage alone keeps the threshold select
                    if (lkey_fire || !uv_fire) begin
                        next_lv_sel = wdlvr_pkg::LV_SELECT_POR;             // [R16]
                    end else begin
                        next_lv_sel = lv_sel;                               // [R17]
                    end
                end else if (overflow) begin
                    next_state = wdlvr_pkg::ST_WAKE;
                    next_hold  = wdlvr_pkg::RESET_HOLD - 3'h1;
                    next_pc_sp = 1'b1;                                      // [R7]
                    next_cnt   = '0;
                end
                if (overflow) begin
                    next_timeout_flag = 1'b1;                               // [R6] [R7]
                end
            end
            wdlvr_pkg::ST_FULL: begin
                next_full  = (hold != 3'h0);
                next_pc_sp = (hold != 3'h0);
                next_port  = (hold != 3'h0);
                next_hold  = hold - 3'h1;
                if (hold == 3'h0) begin
                    next_state = wdlvr_pkg::ST_RUN;
                    next_hold  = 3'h0;
                end
            end
            wdlvr_pkg::ST_WAKE: begin
                next_pc_sp = (hold != 3'h0);
                next_hold  = hold - 3'h1;
                if (hold == 3'h0) begin
                    next_state = wdlvr_pkg::ST_RUN;
                    next_hold  = 3'h0;
                end
            end
            default: begin
                next_state = wdlvr_pkg::ST_RUN;
                next_hold  = 3'h0;
            end
        endcase
    end

    // Reset cause flags: a set in the clearing cycle wins
    always_comb begin
        next_wdt_key_fault_flag = (state == wdlvr_pkg::ST_RUN && wkey_fire)
            || (wdt_key_fault_flag
                && !(wr_rst_ctrl && !wdata_i[wdlvr_pkg::BIT_WKEY_FAULT]));  // [R21]
        next_threshold_key_fault_flag = (state == wdlvr_pkg::ST_RUN && lkey_fire)
            || (threshold_key_fault_flag
                && !(wr_rst_ctrl && !wdata_i[wdlvr_pkg::BIT_LKEY_FAULT]));  // [R15] [R23]
        next_undervolt_reset_flag = (state == wdlvr_pkg::ST_RUN && uv_fire)
            || (undervolt_reset_flag
                && !(wr_rst_ctrl && !wdata_i[wdlvr_pkg::BIT_UV_FLAG]));     // [R12] [R23]
    end

    // Read data, valid only in the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                wdlvr_pkg::ADDR_WDT_CTRL:  next_rdata = wdt_ctrl;
                wdlvr_pkg::ADDR_LV_SELECT: next_rdata = lv_sel;
                wdlvr_pkg::ADDR_RST_CTRL: begin
                    next_rdata[wdlvr_pkg::BIT_WKEY_FAULT] = wdt_key_fault_flag;
                    next_rdata[wdlvr_pkg::BIT_LKEY_FAULT] = threshold_key_fault_flag;
                    next_rdata[wdlvr_pkg::BIT_UV_FLAG]    = undervolt_reset_flag;
                end
                wdlvr_pkg::ADDR_STATUS: begin
                    next_rdata[wdlvr_pkg::BIT_TIMEOUT]  = timeout_flag;
                    next_rdata[wdlvr_pkg::BIT_WDT_RUN]  = wdt_on;
                    next_rdata[wdlvr_pkg::BIT_RST_BUSY] = (state != wdlvr_pkg::ST_RUN);
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state                    <= wdlvr_pkg::ST_RUN;
            hold                     <= 3'h0;
            wdt_ctrl                 <= wdlvr_pkg::WDT_CTRL_POR;             // [R5]
            lv_sel                   <= wdlvr_pkg::LV_SELECT_POR;            // [R18]
            cnt                      <= '0;
            wkey_ticks               <= 2'h0;
            lkey_ticks               <= 2'h0;
            uv_cnt                   <= 7'h00;
            timeout_flag             <= 1'b0;
            wdt_key_fault_flag       <= 1'b0;
            threshold_key_fault_flag <= 1'b0;
            undervolt_reset_flag     <= 1'b0;
            rdata_o                  <= 8'h00;
            full_reset_o             <= 1'b0;
            pc_sp_clear_o            <= 1'b1;                               // [R10]
            port_preset_o            <= 1'b1;                               // [R11]
        end else begin
            state                    <= next_state;
            hold                     <= next_hold;
            wdt_ctrl                 <= next_wdt_ctrl;
            lv_sel                   <= next_lv_sel;
            cnt                      <= next_cnt;
            wkey_ticks               <= next_wkey_ticks;
            lkey_ticks               <= next_lkey_ticks;
            uv_cnt                   <= next_uv_cnt;
            timeout_flag             <= next_timeout_flag;
            wdt_key_fault_flag       <= next_wdt_key_fault_flag;
            threshold_key_fault_flag <= next_threshold_key_fault_flag;
            undervolt_reset_flag     <= next_undervolt_reset_flag;
            rdata_o                  <= next_rdata;
            full_reset_o             <= next_full;
            pc_sp_clear_o            <= next_pc_sp;
            port_preset_o            <= next_port;
        end
    end

    // Checks
    a_overflow_full_reset: assert property ( // [R1]
        @(posedge clk_i) disable iff (!resetn_i)
        (overflow && !sleep_i) |=> full_reset_o && timeout_flag)
        else $error("overflow in run did not give full reset");

    a_disabled_no_count: assert property ( // [R2]
        @(posedge clk_i) disable iff (!resetn_i)
        (wdt_guard_key == wdlvr_pkg::KEY_DISABLE) |-> !overflow ##1 cnt == '0)
        else $error("disabled watchdog is counting");

    a_enabled_counts: assert property ( // [R3]
        @(posedge clk_i) disable iff (!resetn_i)
        (wdt_on && tick && !watchdog_clear_instr_i && !halt_i && cnt != limit && !lkey_fire && !uv_fire
         && state == wdlvr_pkg::ST_RUN && $stable(wdt_ctrl)) |=> cnt == $past(cnt) + 1'b1)
        else $error("enabled watchdog did not advance");

    a_key_fault_delay: assert property ( // [R4]
        @(posedge clk_i) disable iff (!resetn_i)
        (state == wdlvr_pkg::ST_RUN && wkey_fire) |=> full_reset_o && wdt_key_fault_flag)
        else $error("key fault did not reset");

    a_wake_only_pc: assert property ( // [R7]
        @(posedge clk_i) disable iff (!resetn_i)
        (overflow && sleep_i && !wkey_fire && !lkey_fire)
        |=> pc_sp_clear_o && !full_reset_o && !port_preset_o && timeout_flag)
        else $error("sleep overflow gave wrong reset kind");

    a_clear_instr: assert property ( // [R8]
        @(posedge clk_i) disable iff (!resetn_i)
        (watchdog_clear_instr_i || halt_i) |=> cnt == '0)
        else $error("clear instruction left counter running");

    a_uv_ignored_sleep: assert property ( // [R19]
        @(posedge clk_i) disable iff (!resetn_i)
        sleep_i |-> !uv_fire)
        else $error("undervoltage fired in sleep");

    a_uv_keeps_select: assert property ( // [R17]
        @(posedge clk_i) disable iff (!resetn_i)
        (state == wdlvr_pkg::ST_RUN && uv_fire && !lkey_fire && !wr_i)
        |=> lv_sel == $past(lv_sel) && undervolt_reset_flag)
        else $error("undervoltage reset changed threshold select");

    a_lkey_por_select: assert property ( // [R16]
        @(posedge clk_i) disable iff (!resetn_i)
        (state == wdlvr_pkg::ST_RUN && lkey_fire)
        |=> lv_sel == wdlvr_pkg::LV_SELECT_POR && threshold_key_fault_flag)
        else $error("threshold fault did not restore select");

    a_flag_sticky: assert property ( // [R23]
        @(posedge clk_i) disable iff (!resetn_i)
        (undervolt_reset_flag && !wr_rst_ctrl) |=> undervolt_reset_flag)
        else $error("undervoltage flag dropped without software");

    a_reset_hold_len: assert property ( // [R24]
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(full_reset_o) |-> full_reset_o [*4] ##1 !full_reset_o)
        else $error("full reset pulse length wrong");

    a_lkey_fault_reset: assert property ( // [R15]
        @(posedge clk_i) disable iff (!resetn_i)
        (state == wdlvr_pkg::ST_RUN && lkey_fire) |=> full_reset_o && port_preset_o)
        else $error("threshold fault did not reset");

    a_uv_full_reset: assert property ( // [R12]
        @(posedge clk_i) disable iff (!resetn_i)
        (state == wdlvr_pkg::ST_RUN && uv_fire) |=> full_reset_o && undervolt_reset_flag)
        else $error("undervoltage did not reset");

    a_count_on_tick: assert property ( // [R22]
        @(posedge clk_i) disable iff (!resetn_i)
        (wdt_on && !tick && !watchdog_clear_instr_i && !halt_i && !uv_fire) |=> cnt == $past(cnt))
        else $error("counter moved without a slow tick");

    a_port_with_full: assert property ( // [R11]
        @(posedge clk_i) disable iff (!resetn_i)
        full_reset_o |-> port_preset_o)
        else $error("full reset without port preset");

    a_key_delay_min: assert property ( // [R4]
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(key_bad) |-> !wkey_fire [*8])
        else $error("key fault fired too early");
endmodule : wdlvr_top
`default_nettype wire

/* File: dv/wdlvr_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module wdlvr_top_tb;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic [7:0] exp;
    } wdlvr_row_t;

    localparam int TICK = 16;
    localparam int LIMIT = 40000;

    logic       clk_i;
    logic       resetn_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       watchdog_clear_instr_i;
    logic       halt_i;
    logic       sleep_i;
    logic       slow_osc_i;
    logic       undervolt_i;
    logic       full_reset_o;
    logic       pc_sp_clear_o;
    logic       port_preset_o;
    int         fails;
    int         tests_run;
    int         cyc;
    int         n;
    int         w;
    logic       fr;
    logic       ps;
    logic [7:0] d;

    wdlvr_row_t rows [13] = '{
        '{4'h0, 8'h00, 1'b0, 8'h53}, '{4'h2, 8'h00, 1'b0, 8'h55}, '{4'h1, 8'h00, 1'b0, 8'h00},
        '{4'h3, 8'h00, 1'b0, 8'h02}, '{4'h5, 8'hff, 1'b1, 8'h00}, '{4'h3, 8'hff, 1'b1, 8'h02},
        '{4'h2, 8'h33, 1'b1, 8'h33}, '{4'h2, 8'h99, 1'b1, 8'h99}, '{4'h2, 8'haa, 1'b1, 8'haa},
        '{4'h2, 8'h55, 1'b1, 8'h55}, '{4'h0, 8'hab, 1'b1, 8'hab}, '{4'h3, 8'h00, 1'b0, 8'h00},
        '{4'h0, 8'h50, 1'b1, 8'h50}
    };

    wdlvr_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .watchdog_clear_instr_i(watchdog_clear_instr_i), .halt_i(halt_i),
        .sleep_i(sleep_i), .slow_osc_i(slow_osc_i), .undervolt_i(undervolt_i),
        .full_reset_o(full_reset_o), .pc_sp_clear_o(pc_sp_clear_o),
        .port_preset_o(port_preset_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Slow tick at 16 clocks a period, off the rising clock edges to keep the sync honest
    initial begin
        slow_osc_i = 1'b0;
        forever #160 slow_osc_i = ~slow_osc_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            fails++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, got);
        end
    endtask : chk_rng

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd

    task automatic pulse(input bit is_halt);
        @(posedge clk_i);
        if (is_halt) halt_i <= 1'b1;
        else watchdog_clear_instr_i <= 1'b1;
        @(posedge clk_i);
        halt_i <= 1'b0;
        watchdog_clear_instr_i <= 1'b0;
    endtask : pulse

    // Waits for either reset output, then measures how long it stays up
    task automatic wait_out(input int lim, output int cnt, output logic f, output logic p,
                            output int wid);
        cnt = 0;
        wid = 0;
        #1;
        while (cnt < lim && full_reset_o !== 1'b1 && pc_sp_clear_o !== 1'b1) begin
            @(posedge clk_i);
            #1 cnt++;
        end
        f = full_reset_o;
        p = pc_sp_clear_o;
        chk("port preset", f, port_preset_o);
        while (full_reset_o === 1'b1 || pc_sp_clear_o === 1'b1) begin
            @(posedge clk_i);
            #1 wid++;
        end
    endtask : wait_out

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        {cyc, fails, tests_run} = '0;
        {resetn_i, addr_i, wdata_i, wr_i, rd_i, watchdog_clear_instr_i, halt_i, sleep_i, undervolt_i} = '0;
        repeat (4) @(posedge clk_i);
        #1 chk("reset outputs", 3'b011, {full_reset_o, pc_sp_clear_o, port_preset_o});
        @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        #1 chk("released", 3'h0, {full_reset_o, pc_sp_clear_o, port_preset_o});
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, d);
            chk("register", rows[i].exp, d);
        end
        for (int s = 7; s >= 0; s--) begin
            wr(4'h0, 8'h50 | 8'(s));
            rd(4'h0, d);
            chk("period select", 8'h50 | 8'(s), d);
        end
        // Shortest period: overflow after 256 ticks gives a 4 cycle full reset
        pulse(0);
        wait_out(256 * TICK + 40, n, fr, ps, w);
        chk_rng("overflow time", 256 * TICK - 24, 256 * TICK + 24, n);
        chk("overflow kind", 10'h304, {fr, ps, 8'(w)});
        rd(4'h3, d);
        chk("status after overflow", 8'h03, d);
        rd(4'h0, d);
        chk("ctrl after overflow", 8'h53, d);
        // Clears keep it quiet; the halt clear also drops the timeout flag
        wr(4'h0, 8'h50);
        pulse(0);
        for (int i = 0; i < 3; i++) begin
            wait_out(200 * TICK, n, fr, ps, w);
            chk("cleared, no reset", 200 * TICK, n);
            pulse(i == 2);
        end
        rd(4'h3, d);
        chk("status after halt", 8'h02, d);
        // Sleep: undervoltage ignored, overflow clears only pc and stack pointer
        sleep_i <= 1'b1;
        pulse(0);
        undervolt_i <= 1'b1;
        wait_out(120, n, fr, ps, w);
        chk("undervolt in sleep", 120, n);
        undervolt_i <= 1'b0;
        wait_out(256 * TICK + 40, n, fr, ps, w);
        chk("sleep overflow", 10'h104, {fr, ps, 8'(w)});
        sleep_i <= 1'b0;
        rd(4'h3, d);
        chk("status after sleep", 8'h03, d);
        wr(4'h0, 8'hab);
        wait_out(300 * TICK, n, fr, ps, w);
        chk("disabled, no reset", 300 * TICK, n);
        // Bad guard key and bad threshold code both reset after 2 to 3 ticks
        for (int k = 0; k < 2; k++) begin
            if (k == 1) wr(4'h2, 8'h33);
            wr(4'(k * 2), 8'h12);
            wait_out(6 * TICK, n, fr, ps, w);
            chk_rng("key fault delay", 2 * TICK - 8, 3 * TICK + 12, n);
            chk("key fault reset", 1'b1, fr);
            rd(4'h1, d);
            chk("fault flag", 8'(k + 1), d);
            rd(4'h0, d);
            chk("ctrl reload", 8'h53, d);
            rd(4'h2, d);
            chk("threshold reload", 8'h55, d);
            wr(4'h1, 8'hff);
            rd(4'h1, d);
            chk("flag write one", 8'(k + 1), d);
            wr(4'h1, 8'h00);
        end
        // Undervoltage: short pulse ignored, long level resets and keeps select
        wr(4'h2, 8'h99);
        undervolt_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        undervolt_i <= 1'b0;
        wait_out(100, n, fr, ps, w);
        chk("short undervolt", 100, n);
        undervolt_i <= 1'b1;
        wait_out(120, n, fr, ps, w);
        undervolt_i <= 1'b0;
        chk_rng("undervolt delay", 45, 60, n);
        chk("undervolt reset", 1'b1, fr);
        rd(4'h1, d);
        chk("undervolt flag", 8'h04, d);
        rd(4'h2, d);
        chk("threshold kept", 8'h99, d);
        wr(4'h1, 8'h00);
        rd(4'h1, d);
        chk("flags cleared", 8'h00, d);
        test_done();
    end
endmodule : wdlvr_top_tb
`default_nettype wire
